// ---- dv/dpc_ctrl_model.sv ----
`default_nettype none

module dpc_ctrl_model (
    input  wire logic                    mclk,
    output logic                         ck,
    output logic                         cs_n,
    output logic                         ras_n,
    output logic                         cas_n,
    output logic                         we_n,
    output logic [dpc_pkg::BA_W-1:0]     ba,
    output logic [dpc_pkg::AD_W-1:0]     addr,
    output logic [dpc_pkg::DQ_W-1:0]     dq,
    output logic                         dqs,
    output logic [1:0]                   dm
);
    timeunit 1ns;
    timeprecision 100ps;
    import dpc_pkg::*;

    initial begin
        ck = 1'b0;
        {cs_n, ras_n, cas_n, we_n} = 4'hF;
        ba = '0;
        addr = '0;
        dq = '0;
        dqs = 1'b0;
        dm = 2'h0;
    end

    always #40 ck = ~ck;

    // Pins move at the first MCLK fall once CK has fallen, at least 30 ns clear of the sampling rise.
    // Released lines show the inverse so a late sample cannot pass by luck.
    task automatic cmd(input logic [3:0] code, input logic [2:0] b, input logic [13:0] a);
        @(negedge ck);
        @(negedge mclk);
        {cs_n, ras_n, cas_n, we_n} = code;
        ba = b;
        addr = a;
        @(negedge ck);
        @(negedge mclk);
        cs_n = 1'b1;
        ba = ~b;
        addr = ~a;
        @(negedge ck);
    endtask

    task automatic wr_burst(input logic [63:0] d, input logic [3:0] m);
        @(negedge ck);
        for (int i = 0; i < 4; i++) begin
            dq = d[16*i +: 16];
            dm = {2{m[i]}};
            #20 dqs = ~dqs;
            #20;
        end
        dq = ~dq;
        dm = 2'h0;
    endtask
endmodule

`default_nettype wire

// ---- dv/dpc_pin_cmd_test.sv ----
`default_nettype none

module dpc_pin_cmd_test;
    timeunit 1ns;
    timeprecision 100ps;
    import dpc_pkg::*;

    localparam logic [13:0] MV [4] = '{14'h0022, 14'h0404, 14'h0155, 14'h02AA};
    logic              mclk = 1'b0;
    logic              resetn = 1'b0;
    logic              termination_control = 1'b0;
    logic              wr_ready = 1'b0;
    logic              x16 = 1'b1;
    wire               ck, cs_n, ras_n, cas_n, we_n, dqs, dq_oe, wr_valid, overrun;
    wire               stb_o, read_only_strobe_oe;
    wire  [2:0]        ba, rd_bank, term;
    wire  [13:0]       addr, rd_row;
    wire  [3:0][13:0]  mr;
    wire  [15:0]       dq, dq_o;
    wire  [1:0]        dm, soe;
    wire  [9:0]        rd_col;
    wire  [7:0]        bank_open;
    wire  [WORD_W-1:0] wr_data;
    logic [WORD_W-1:0] q[$];
    int                error_cnt = 0;
    int                checks_done = 0;

    always #5 mclk = ~mclk;

    dpc_ctrl_model dpc_ctrl_model_i (.mclk(mclk), .ck(ck), .cs_n(cs_n), .ras_n(ras_n),
        .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dq(dq), .dqs(dqs), .dm(dm));

    // Clock enable stays high throughout, as accesses require.
    dpc_pin_cmd dpc_pin_cmd_i (.MCLK(mclk), .RESETN(resetn), .X16_PART(x16), .CK(ck),
        .CKE(1'b1), .CS_N(cs_n), .RAS_N(ras_n), .CAS_N(cas_n), .WE_N(we_n),
        .BANK_SELECT(ba), .ROW_COL_ADDRESS(addr), .TERMINATION_CONTROL(termination_control), .DQ_I(dq),
        .DQ_O(dq_o), .DQ_OE(dq_oe), .LOWER_BYTE_STROBE_I(dqs), .LOWER_BYTE_STROBE_O(stb_o),
        .LOWER_BYTE_STROBE_OE(soe[0]), .LOWER_BYTE_STROBE_N_O(), .LOWER_BYTE_STROBE_N_OE(),
        .UPPER_BYTE_STROBE_I(dqs), .UPPER_BYTE_STROBE_O(), .UPPER_BYTE_STROBE_OE(soe[1]),
        .UPPER_BYTE_STROBE_N_O(), .UPPER_BYTE_STROBE_N_OE(), .LOWER_BYTE_WRITE_MASK(dm[0]),
        .UPPER_BYTE_WRITE_MASK(dm[1]), .READ_ONLY_STROBE_O(), .READ_ONLY_STROBE_OE(read_only_strobe_oe),
        .TERM_DQ_EN(term[0]), .TERM_STROBE_EN(term[1]), .TERM_MASK_EN(term[2]),
        .MODE_REG(mr[0]), .EXT_MODE_REG_ONE(mr[1]), .EXT_MODE_REG_TWO(mr[2]),
        .EXT_MODE_REG_THREE(mr[3]), .BANK_OPEN(bank_open), .RD_ADDR_BANK(rd_bank),
        .RD_ADDR_ROW(rd_row), .RD_ADDR_COL(rd_col), .RD_DATA({6'h00, rd_col}),
        .WR_VALID(wr_valid), .WR_READY(wr_ready), .WR_DATA(wr_data), .WR_OVERRUN(overrun));

    always @(posedge mclk) if (wr_valid === 1'b1 && wr_ready) q.push_back(wr_data);

    function automatic logic [WORD_W-1:0] w(input logic [15:0] d, input logic [9:0] c);
        return {2'h3, d, 3'h2, 14'h1234, c};
    endfunction

    task automatic chk(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    initial begin
        repeat (10) @(negedge mclk);
        resetn = 1'b1;
        repeat (4) @(negedge mclk);
        chk(mr[0], MR_RST);
        for (int i = 0; i < 4; i++) dpc_ctrl_model_i.cmd(CMD_MODE_SET, 3'(i), MV[i]);
        for (int i = 0; i < 4; i++) chk(mr[i], MV[i]);
        termination_control = 1'b1;
        dpc_ctrl_model_i.cmd(4'h8, 3'h0, 14'h0033);
        chk(mr[0], MV[0]);
        chk(term, 3'h7);
        dpc_ctrl_model_i.cmd(CMD_MODE_SET, 3'h1, 14'h0000);
        dpc_ctrl_model_i.cmd(4'h8, 3'h0, 14'h0000);
        chk(term, 3'h0);
        termination_control = 1'b0;
        dpc_ctrl_model_i.cmd(CMD_ACTIVATE, 3'h2, 14'h1234);
        dpc_ctrl_model_i.cmd(CMD_WRITE, 3'h2, 14'h0004);
        dpc_ctrl_model_i.wr_burst(64'h4444_3333_2222_1111, 4'h2);
        for (int i = 0; i < 2; i++) begin
            dpc_ctrl_model_i.cmd(CMD_WRITE, 3'h2, {3'h0, i[0], 10'h000});
            dpc_ctrl_model_i.wr_burst(64'h8888_7777_6666_5555, 4'h0);
        end
        repeat (8) @(negedge mclk);
        chk(overrun, 1'b1);
        chk(bank_open[2], 1'b0);
        wr_ready = 1'b1;
        repeat (20) @(negedge mclk);
        chk(q.size(), 9);
        chk(q[0], w(16'h1111, 10'h004));
        chk(q[1], w(16'h3333, 10'h006));
        chk(q[2], w(16'h4444, 10'h007));
        chk(q[8], w(16'h6666, 10'h001));
        dpc_ctrl_model_i.cmd(CMD_ACTIVATE, 3'h5, 14'h0ABC);
        dpc_ctrl_model_i.cmd(CMD_READ, 3'h5, 14'h0008);
        chk(rd_bank, 3'h5);
        chk(rd_row, 14'h0ABC);
        for (int n = 0; n < 50 && dq_oe !== 1'b1; n++) @(negedge mclk);
        chk(dq_oe, 1'b1);
        chk(soe, 2'h3);
        // Each beat is announced by a strobe toggle; the data stands until the next one.
        for (int b = 0; b < 4; b++) begin
            for (int n = 0; n < 8 && stb_o == b[0]; n++) @(negedge mclk);
            chk(dq_o, 16'h0008 + 16'(b));
        end
        repeat (40) @(negedge mclk);
        dpc_ctrl_model_i.cmd(CMD_ACTIVATE, 3'h1, 14'h0000);
        dpc_ctrl_model_i.cmd(CMD_ACTIVATE, 3'h6, 14'h0000);
        chk(bank_open, 8'h62);
        dpc_ctrl_model_i.cmd(CMD_PRECHARGE, 3'h1, 14'h0000);
        chk(bank_open, 8'h60);
        dpc_ctrl_model_i.cmd(CMD_PRECHARGE, 3'h0, 14'h0400);
        chk(bank_open, 8'h00);
        x16 = 1'b0;
        dpc_ctrl_model_i.cmd(CMD_MODE_SET, 3'h1, 14'h0800);
        dpc_ctrl_model_i.cmd(CMD_ACTIVATE, 3'h3, 14'h0001);
        dpc_ctrl_model_i.cmd(CMD_READ, 3'h3, 14'h0000);
        for (int n = 0; n < 50 && dq_oe !== 1'b1; n++) @(negedge mclk);
        chk({read_only_strobe_oe, soe}, 3'h5);
        results();
    end

    initial begin
        #50us;
        error_cnt++;
        results();
    end
endmodule

`default_nettype wire

// ---- hw/dpc_fifo.sv ----
`default_nettype none

module dpc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             mclk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;

    wire push = in_valid && in_ready;
    // The output register is refilled whenever it is empty or being drained.
    wire load = (count != '0) && (!out_valid || out_ready);

    assign in_ready = (count != FULL);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr    <= '0;
            rd_ptr    <= '0;
            count     <= '0;
            out_valid <= 1'b0;
            out_data  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + AW'(1);
            end
            if (load) begin
                rd_ptr <= rd_ptr + AW'(1);
            end
            count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
            if (load) begin
                out_valid <= 1'b1;
                out_data  <= mem[rd_ptr];
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

endmodule

`default_nettype wire

// ---- hw/dpc_pin_cmd.sv ----
// Operation
// - Fully masked write beats are discarded.
// - Mask sampled on both strobe edges.
// - x8 mask pin may become read strobe.
// - Bank select names the command's bank.
// - Bank select picks which mode register.
// - Scope bit: one bank or all banks.
// - Mode register value taken from address.
// - Strobe driven on reads, received on writes.
// - Lower strobe low byte, upper high byte.
// - Complement strobes switched by register bit.
// - Registered termination input enables termination.
// - x16 termination covers data, strobes, masks.
// - Termination input ignored when disabled.
// - Bursts of four or eight, programmed order.
// - Activate takes bank and row address.
// - Read/write take column and auto-precharge.
// - Commands ignored while select is high.
`default_nettype none

module dpc_pin_cmd (
    input  wire logic                       MCLK,
    input  wire logic                       RESETN,
    input  wire logic                       X16_PART,
    input  wire logic                       CK,
    input  wire logic                       CKE,
    input  wire logic                       CS_N,
    input  wire logic                       RAS_N,
    input  wire logic                       CAS_N,
    input  wire logic                       WE_N,
    input  wire logic [dpc_pkg::BA_W-1:0]   BANK_SELECT,
    input  wire logic [dpc_pkg::AD_W-1:0]   ROW_COL_ADDRESS,
    input  wire logic                       TERMINATION_CONTROL,
    input  wire logic [dpc_pkg::DQ_W-1:0]   DQ_I,
    output logic      [dpc_pkg::DQ_W-1:0]   DQ_O,
    output logic                            DQ_OE,
    input  wire logic                       LOWER_BYTE_STROBE_I,
    output logic                            LOWER_BYTE_STROBE_O,
    output logic                            LOWER_BYTE_STROBE_OE,
    output logic                            LOWER_BYTE_STROBE_N_O,
    output logic                            LOWER_BYTE_STROBE_N_OE,
    input  wire logic                       UPPER_BYTE_STROBE_I,
    output logic                            UPPER_BYTE_STROBE_O,
    output logic                            UPPER_BYTE_STROBE_OE,
    output logic                            UPPER_BYTE_STROBE_N_O,
    output logic                            UPPER_BYTE_STROBE_N_OE,
    input  wire logic                       LOWER_BYTE_WRITE_MASK,
    input  wire logic                       UPPER_BYTE_WRITE_MASK,
    output logic                            READ_ONLY_STROBE_O,
    output logic                            READ_ONLY_STROBE_OE,
    output logic                            TERM_DQ_EN,
    output logic                            TERM_STROBE_EN,
    output logic                            TERM_MASK_EN,
    output logic      [dpc_pkg::AD_W-1:0]   MODE_REG,
    output logic      [dpc_pkg::AD_W-1:0]   EXT_MODE_REG_ONE,
    output logic      [dpc_pkg::AD_W-1:0]   EXT_MODE_REG_TWO,
    output logic      [dpc_pkg::AD_W-1:0]   EXT_MODE_REG_THREE,
    output logic      [dpc_pkg::NUM_BANKS-1:0] BANK_OPEN,
    output logic      [dpc_pkg::BA_W-1:0]   RD_ADDR_BANK,
    output logic      [dpc_pkg::AD_W-1:0]   RD_ADDR_ROW,
    output logic      [dpc_pkg::COL_W-1:0]  RD_ADDR_COL,
    input  wire logic [dpc_pkg::DQ_W-1:0]   RD_DATA,
    output logic                            WR_VALID,
    input  wire logic                       WR_READY,
    output logic      [dpc_pkg::WORD_W-1:0] WR_DATA,
    output logic                            WR_OVERRUN
);
    import dpc_pkg::*;

    localparam int PIN_W = 12 + BA_W + AD_W + DQ_W;

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RESETN);

    function automatic logic [COL_W-1:0] beat_col(input logic [COL_W-1:0] c,
                                                  input logic [2:0] i,
                                                  input logic eight,
                                                  input logic inter);
        logic [2:0] low;
        low = inter ? (c[2:0] ^ i) : (c[2:0] + i);
        return eight ? {c[COL_W-1:3], low} : {c[COL_W-1:2], low[1:0]};
    endfunction

    // Every pin passes three flops; a bit is accepted once stages two and three agree.
    logic [PIN_W-1:0] s1, s2, s3, pin;
    wire  [PIN_W-1:0] pin_raw = {CK, CKE, CS_N, RAS_N, CAS_N, WE_N, BANK_SELECT,
                                 ROW_COL_ADDRESS, TERMINATION_CONTROL, UPPER_BYTE_STROBE_I,
                                 LOWER_BYTE_STROBE_I, UPPER_BYTE_WRITE_MASK,
                                 LOWER_BYTE_WRITE_MASK, DQ_I, X16_PART};
    wire  [PIN_W-1:0] next_pin = (s3 & ~(s2 ^ s3)) | (pin & (s2 ^ s3));

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            s1  <= '0;
            s2  <= '0;
            s3  <= '0;
            pin <= '0;
        end else begin
            s1  <= pin_raw;
            s2  <= s1;
            s3  <= s2;
            pin <= next_pin;
        end
    end

    wire            ck, cke, cs_n, ras_n, cas_n, we_n, termination_control, x16;
    wire [BA_W-1:0] ba;
    wire [AD_W-1:0] addr;
    wire [1:0]      stb, dmask;
    wire [DQ_W-1:0] dq;
    assign {ck, cke, cs_n, ras_n, cas_n, we_n, ba, addr, termination_control, stb, dmask, dq, x16} = pin;

    logic       ck_prev;
    logic [1:0] stb_prev;
    wire        ck_rise = ck & ~ck_prev;
    wire        ck_edge = ck ^ ck_prev;

    wire [3:0] cmd    = {cs_n, ras_n, cas_n, we_n};
    wire       cmd_ok = ck_rise & cke & ~cs_n;
    wire       is_mrs = cmd_ok && cmd == CMD_MODE_SET && !ba[BA_W-1];
    wire       is_pre = cmd_ok && cmd == CMD_PRECHARGE;
    wire       is_act = cmd_ok && cmd == CMD_ACTIVATE;
    wire       is_rd  = cmd_ok && cmd == CMD_READ;
    wire       is_wr  = cmd_ok && cmd == CMD_WRITE;

    logic [AD_W-1:0] mreg [NUM_MREGS];
    assign MODE_REG           = mreg[0];
    assign EXT_MODE_REG_ONE   = mreg[1];
    assign EXT_MODE_REG_TWO   = mreg[2];
    assign EXT_MODE_REG_THREE = mreg[3];

    wire [AD_W-1:0] emr1    = mreg[MSEL_EMR1];
    wire            bl8     = mreg[MSEL_MR][MR_BL_LSB +: 3] == BL_EIGHT;
    wire            inter   = mreg[MSEL_MR][MR_BT_BIT];
    wire [2:0]      cl      = mreg[MSEL_MR][MR_CL_LSB +: 3];
    wire [2:0]      cl_eff  = (cl == 3'h0) ? CL_MIN : cl;
    wire [3:0]      nbeats  = bl8 ? 4'h8 : 4'h4;
    wire [2:0]      last_bt = bl8 ? 3'h7 : 3'h3;
    wire            read_only_strobe_en = ~x16 & emr1[EMR1_READ_ONLY_STROBE_EN];
    wire            comp_en = ~emr1[EMR1_COMP_DIS];
    wire            rtt_on  = emr1[EMR1_RTT_HI] | emr1[EMR1_RTT_LO];

    logic [AD_W-1:0]      open_row [NUM_BANKS];
    logic [NUM_BANKS-1:0] bank_open, next_bank_open;
    assign BANK_OPEN = bank_open;

    // Read engine state.
    dpc_rd_e          rd_state;
    logic [3:0]       rd_hc, rd_beat;
    logic [BA_W-1:0]  rd_bank;
    logic [AD_W-1:0]  rd_row;
    logic [COL_W-1:0] rd_col;
    logic             rd_ap, rd_strobe, rd_oe;

    // Write engine state.
    logic             wr_active, wr_ap;
    logic [BA_W-1:0]  wr_bank;
    logic [AD_W-1:0]  wr_row;
    logic [COL_W-1:0] wr_col;
    logic [2:0]       wr_beat;
    logic             lane_has [2];
    logic             lane_mask [2];
    logic [7:0]       lane_byte [2];

    // Accesses to a closed bank are dropped; the controller opens rows first.
    wire idle     = rd_state == RD_IDLE && !wr_active;
    wire rd_start = is_rd && bank_open[ba] && idle;
    wire wr_start = is_wr && bank_open[ba] && idle;
    wire rd_pre   = rd_state == RD_WAIT && ck_edge && rd_hc == 4'h1;
    wire rd_now   = rd_state == RD_BURST && ck_edge && rd_beat != nbeats;
    wire rd_done  = rd_state == RD_BURST && ck_edge && rd_beat == nbeats;
    wire next_strobe = rd_pre ? 1'b0 : (rd_now ? ~rd_strobe : rd_strobe);
    wire next_oe     = rd_pre | (rd_oe & ~rd_done);

    wire       pair_done = lane_has[0] & (lane_has[1] | ~x16);
    wire [1:0] keep      = {x16 & ~lane_mask[1], ~lane_mask[0]};
    wire       fifo_push = pair_done && keep != 2'h0;
    wire       fifo_rdy;
    wire       wr_last   = pair_done && wr_beat == last_bt;
    wire       ap_close  = (rd_done & rd_ap) | (wr_last & wr_ap);
    wire [BA_W-1:0]   ap_bank  = rd_done ? rd_bank : wr_bank;
    wire [COL_W-1:0]  wr_cur   = beat_col(wr_col, wr_beat, bl8, inter);
    wire [WORD_W-1:0] fifo_in  = {keep, lane_byte[1], lane_byte[0], wr_bank, wr_row, wr_cur};

    always_comb begin
        next_bank_open = bank_open;
        if (ap_close) begin
            next_bank_open[ap_bank] = 1'b0;
        end
        if (is_pre) begin
            if (addr[PRE_SCOPE_BIT]) begin
                next_bank_open = '0;
            end else begin
                next_bank_open[ba] = 1'b0;
            end
        end
        if (is_act) begin
            next_bank_open[ba] = 1'b1;
        end
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            ck_prev   <= 1'b0;
            stb_prev  <= 2'h0;
            bank_open <= '0;
            for (int i = 0; i < NUM_MREGS; i++) begin
                mreg[i] <= (i == 0) ? MR_RST : EMR_RST;
            end
            for (int i = 0; i < NUM_BANKS; i++) begin
                open_row[i] <= '0;
            end
        end else begin
            ck_prev   <= ck;
            stb_prev  <= stb;
            bank_open <= next_bank_open;
            if (is_mrs) begin
                mreg[ba[1:0]] <= addr;
            end
            if (is_act) begin
                open_row[ba] <= addr;
            end
        end
    end

    // Read: preamble one half clock before the first beat, data on every clock edge.
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            rd_state <= RD_IDLE;
            rd_hc    <= 4'h0;
            rd_beat  <= 4'h0;
            rd_bank  <= '0;
            rd_row   <= '0;
            rd_col   <= '0;
            rd_ap    <= 1'b0;
        end else begin
            unique case (rd_state)
                RD_IDLE: begin
                    if (rd_start) begin
                        rd_state <= RD_WAIT;
                        rd_hc    <= {cl_eff, 1'b0} - 4'h1;
                        rd_bank  <= ba;
                        rd_row   <= open_row[ba];
                        rd_col   <= addr[COL_W-1:0];
                        rd_ap    <= addr[AUTO_PRE_BIT];
                    end
                end
                RD_WAIT: begin
                    if (ck_edge) begin
                        rd_hc <= rd_hc - 4'h1;
                    end
                    if (rd_pre) begin
                        rd_state <= RD_BURST;
                        rd_beat  <= 4'h0;
                    end
                end
                RD_BURST: begin
                    if (rd_now) begin
                        rd_beat <= rd_beat + 4'h1;
                    end
                    if (rd_done) begin
                        rd_state <= RD_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            rd_oe                  <= 1'b0;
            rd_strobe              <= 1'b0;
            DQ_O                   <= '0;
            DQ_OE                  <= 1'b0;
            LOWER_BYTE_STROBE_N_O  <= 1'b1;
            UPPER_BYTE_STROBE_N_O  <= 1'b1;
            LOWER_BYTE_STROBE_OE   <= 1'b0;
            UPPER_BYTE_STROBE_OE   <= 1'b0;
            LOWER_BYTE_STROBE_N_OE <= 1'b0;
            UPPER_BYTE_STROBE_N_OE <= 1'b0;
            READ_ONLY_STROBE_O     <= 1'b0;
            READ_ONLY_STROBE_OE    <= 1'b0;
            RD_ADDR_COL            <= '0;
        end else begin
            rd_oe                  <= next_oe;
            rd_strobe              <= next_strobe;
            DQ_OE                  <= next_oe;
            if (rd_now) begin
                DQ_O <= RD_DATA;
            end
            LOWER_BYTE_STROBE_N_O  <= ~next_strobe;
            UPPER_BYTE_STROBE_N_O  <= ~next_strobe;
            LOWER_BYTE_STROBE_OE   <= next_oe;
            UPPER_BYTE_STROBE_OE   <= next_oe & x16;
            LOWER_BYTE_STROBE_N_OE <= next_oe & comp_en;
            UPPER_BYTE_STROBE_N_OE <= next_oe & x16 & comp_en;
            READ_ONLY_STROBE_O     <= next_strobe;
            READ_ONLY_STROBE_OE    <= next_oe & read_only_strobe_en;
            if (rd_pre) begin
                RD_ADDR_COL <= beat_col(rd_col, 3'h0, bl8, inter);
            end else if (rd_now) begin
                RD_ADDR_COL <= beat_col(rd_col, rd_beat[2:0] + 3'h1, bl8, inter);
            end
        end
    end

    assign LOWER_BYTE_STROBE_O = rd_strobe;
    assign UPPER_BYTE_STROBE_O = rd_strobe;
    assign RD_ADDR_BANK        = rd_bank;
    assign RD_ADDR_ROW         = rd_row;

    // Write: each byte lane captures data and mask on both edges of its own strobe.
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_lane
            wire take = wr_active & (stb[g] ^ stb_prev[g]);
            always_ff @(posedge MCLK or negedge RESETN) begin
                if (!RESETN) begin
                    lane_has[g]  <= 1'b0;
                    lane_mask[g] <= 1'b0;
                    lane_byte[g] <= 8'h00;
                end else begin
                    lane_has[g] <= take | (lane_has[g] & ~pair_done);
                    if (take) begin
                        lane_byte[g] <= dq[8*g +: 8];
                        lane_mask[g] <= dmask[g] & ~((g == 0) & read_only_strobe_en);
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            wr_active  <= 1'b0;
            wr_ap      <= 1'b0;
            wr_bank    <= '0;
            wr_row     <= '0;
            wr_col     <= '0;
            wr_beat    <= 3'h0;
            WR_OVERRUN <= 1'b0;
        end else begin
            if (wr_start) begin
                wr_active <= 1'b1;
                wr_bank   <= ba;
                wr_row    <= open_row[ba];
                wr_col    <= addr[COL_W-1:0];
                wr_ap     <= addr[AUTO_PRE_BIT];
                wr_beat   <= 3'h0;
            end else if (pair_done) begin
                wr_beat <= wr_beat + 3'h1;
                if (wr_last) begin
                    wr_active <= 1'b0;
                end
            end
            // The link cannot be stalled, so a beat that finds the buffer full is lost.
            if (fifo_push && !fifo_rdy) begin
                WR_OVERRUN <= 1'b1;
            end
        end
    end

    dpc_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .mclk     (MCLK),
        .rst_n    (RESETN),
        .in_valid (fifo_push),
        .in_ready (fifo_rdy),
        .in_data  (fifo_in),
        .out_valid(WR_VALID),
        .out_ready(WR_READY),
        .out_data (WR_DATA)
    );

    // Termination follows the input registered on the clock's rising edge.
    logic odt_reg;
    wire  next_term = odt_reg & rtt_on;

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            odt_reg        <= 1'b0;
            TERM_DQ_EN     <= 1'b0;
            TERM_STROBE_EN <= 1'b0;
            TERM_MASK_EN   <= 1'b0;
        end else begin
            if (ck_rise) begin
                odt_reg <= termination_control;
            end
            TERM_DQ_EN     <= next_term;
            TERM_STROBE_EN <= next_term;
            TERM_MASK_EN   <= next_term & ~read_only_strobe_en;
        end
    end

    sequence s_preamble;
        rd_pre ##1 DQ_OE && !LOWER_BYTE_STROBE_O;
    endsequence

    AST_MASKED_DROP: assert property (pair_done && lane_mask[0] && (lane_mask[1] || !x16)
                                      |-> !fifo_push)
        else $error("fully masked beat was stored");
    AST_DESELECT: assert property (ck_rise && cs_n && idle |=> $stable(bank_open))
        else $error("deselected command changed bank state");
    AST_EMR1_WRITE: assert property (is_mrs && ba == 3'h1
                                     |=> EXT_MODE_REG_ONE == $past(addr))
        else $error("extended mode register one not written");
    AST_PRE_ALL: assert property (is_pre && addr[PRE_SCOPE_BIT] |=> BANK_OPEN == '0)
        else $error("precharge all left a bank open");
    AST_ACT_ROW: assert property (is_act |=> open_row[$past(ba)] == $past(addr))
        else $error("activate did not record the row");
    AST_TERM_OFF: assert property (!rtt_on |=> !TERM_DQ_EN)
        else $error("termination on while disabled");
    AST_PREAMBLE: assert property (s_preamble |=> ##[0:20] rd_now)
        else $error("no data beat after read preamble");
    AST_BEAT_ALIGN: assert property (rd_now |=> DQ_O == $past(RD_DATA) &&
                                     LOWER_BYTE_STROBE_O != $past(LOWER_BYTE_STROBE_O))
        else $error("read data and strobe edge not aligned");
    AST_COMP_OFF: assert property (emr1[EMR1_COMP_DIS] && $past(emr1[EMR1_COMP_DIS])
                                   |-> !LOWER_BYTE_STROBE_N_OE)
        else $error("complement strobe driven while disabled");

endmodule

`default_nettype wire

// ---- hw/dpc_pkg.sv ----
`default_nettype none

package dpc_pkg;

    localparam int DQ_W       = 16;
    localparam int BA_W       = 3;
    localparam int AD_W       = 14;
    localparam int COL_W      = 10;
    localparam int NUM_BANKS  = 8;
    localparam int NUM_MREGS  = 4;
    localparam int WORD_W     = 2 + DQ_W + BA_W + AD_W + COL_W;
    localparam int FIFO_DEPTH = 8;

    // Command code is {select_n, ras_n, cas_n, we_n}.
    localparam logic [3:0] CMD_MODE_SET  = 4'h0;
    localparam logic [3:0] CMD_PRECHARGE = 4'h2;
    localparam logic [3:0] CMD_ACTIVATE  = 4'h3;
    localparam logic [3:0] CMD_WRITE     = 4'h4;
    localparam logic [3:0] CMD_READ      = 4'h5;

    localparam int MR_BL_LSB  = 0;
    localparam int MR_BT_BIT  = 3;
    localparam int MR_CL_LSB  = 4;
    localparam logic [2:0] BL_EIGHT = 3'h3;
    localparam logic [2:0] CL_MIN   = 3'h1;

    localparam int EMR1_RTT_LO   = 2;
    localparam int EMR1_RTT_HI   = 6;
    localparam int EMR1_COMP_DIS = 10;
    localparam int EMR1_READ_ONLY_STROBE_EN  = 11;

    localparam int PRE_SCOPE_BIT = 10;
    localparam int AUTO_PRE_BIT  = 10;

    localparam logic [1:0] MSEL_MR   = 2'h0;
    localparam logic [1:0] MSEL_EMR1 = 2'h1;

    localparam logic [13:0] MR_RST  = 14'h0032;
    localparam logic [13:0] EMR_RST = 14'h0000;

    typedef enum logic [1:0] {
        RD_IDLE,
        RD_WAIT,
        RD_BURST
    } dpc_rd_e;

endpackage

`default_nettype wire
